// ---- verilog/lcdcs_pkg.sv ----
// Package of constants and types for the LCD cascade sync block
package lcdcs_pkg;
  // Multiplex modes
  localparam logic [1:0] LCDCS_MUX_STATIC = 2'h0;
  localparam logic [1:0] LCDCS_MUX_2 = 2'h1;
  localparam logic [1:0] LCDCS_MUX_3 = 2'h2;
  localparam logic [1:0] LCDCS_MUX_4 = 2'h3;
  // Frame clock ticks per backplane phase
  localparam int LCDCS_TICKS_PER_PHASE = 4;
  localparam logic [3:0] LCDCS_PHASE_TICKS = 4'h4;
  // Reset values
  localparam logic [1:0] LCDCS_PHASE_RST = 2'h0;
  localparam logic [3:0] LCDCS_TICK_RST = 4'h0;
  localparam logic [2:0] LCDCS_SUBADDR_RST = 3'h0;
  // Input synchroniser depth
  localparam int LCDCS_SYNC_STAGES = 3;
  // Controller frame clock divider, 100 MHz sys_clk
  localparam int LCDCS_SYS_CLK_HZ = 100000000;
  localparam int LCDCS_FRAME_CLK_HZ = 2000;
  localparam int LCDCS_FRAME_DIV = LCDCS_SYS_CLK_HZ / LCDCS_FRAME_CLK_HZ;
  localparam logic [15:0] LCDCS_DIV_RST = 16'h0000;
  // Controller command states
  typedef enum logic [2:0] {
    LCDCS_IDLE = 3'b001,
    LCDCS_SEL = 3'b010,
    LCDCS_DATA = 3'b100
  } lcdcs_state_e;
endpackage

// ---- verilog/lcdcs_if.sv ----
// Interface joining a cascaded driver and its controller
interface lcdcs_if;
  import lcdcs_pkg::*;
  logic frame_tick;
  logic sel_valid;
  logic [2:0] sel_subaddr;
  logic sel_cluster;
  logic data_valid;
  logic [7:0] data_byte;
  logic [1:0] mux_mode;
  logic lockstep_o;
  logic lockstep_oe;
  logic lockstep_i;
  // Pull from the other drivers sharing the line
  logic lockstep_far;
  // Open drain line with pull-up, shared by the cascade
  assign lockstep_i = ~((lockstep_oe & ~lockstep_o) | lockstep_far);
  modport device (
    input frame_tick, sel_valid, sel_subaddr, sel_cluster, data_valid, data_byte, mux_mode,
    output lockstep_o, lockstep_oe,
    input lockstep_i
  );
  modport ctrl (
    output frame_tick, sel_valid, sel_subaddr, sel_cluster, data_valid, data_byte, mux_mode,
    input lockstep_i
  );
endinterface

// ---- verilog/lcdcs_device.sv ----
// Cascade addressing and frame lockstep logic of one LCD driver
// ==========================================
module lcdcs_device
  import lcdcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  lcdcs_if.device link,
  input wire logic hw_subaddr_bit_zero,
  input wire logic hw_subaddr_bit_one,
  input wire logic hw_subaddr_bit_two,
  input wire logic slave_address_cluster_select,
  input wire logic clock_source_select_pin,
  output logic [1:0] bp_phase,
  output logic frame_start,
  output logic data_accept,
  output logic [7:0] data_out
);
  // ==========================================
  // Pin synchronisers
  logic [3:0] pin_sync_reg [LCDCS_SYNC_STAGES];
  logic [3:0] pin_sync_next [LCDCS_SYNC_STAGES];
  logic [2:0] subaddr_reg;
  logic [2:0] subaddr_next;
  logic cluster_reg;
  logic cluster_next;
  always_comb
  begin
    pin_sync_next[0] = {slave_address_cluster_select, hw_subaddr_bit_two, hw_subaddr_bit_one,
      hw_subaddr_bit_zero};
    for (int i = 1; i < LCDCS_SYNC_STAGES; i++)
      pin_sync_next[i] = pin_sync_reg[i-1];
    subaddr_next = subaddr_reg;
    cluster_next = cluster_reg;
    // Levels count once the last two stages agree
    if (pin_sync_reg[1] == pin_sync_reg[2])
    begin
      subaddr_next = pin_sync_reg[2][2:0];
      cluster_next = pin_sync_reg[2][3];
    end
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < LCDCS_SYNC_STAGES; i++)
        pin_sync_reg[i] <= {1'b0, LCDCS_SUBADDR_RST};
      subaddr_reg <= LCDCS_SUBADDR_RST;
      cluster_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < LCDCS_SYNC_STAGES; i++)
        pin_sync_reg[i] <= pin_sync_next[i];
      subaddr_reg <= subaddr_next;
      cluster_reg <= cluster_next;
    end
  end
  // ==========================================
  // Lockstep line monitor
  logic [LCDCS_SYNC_STAGES-1:0] lock_sync_reg;
  logic [LCDCS_SYNC_STAGES-1:0] lock_sync_next;
  logic lock_seen_reg;
  logic lock_seen_next;
  always_comb
  begin
    lock_sync_next = {lock_sync_reg[LCDCS_SYNC_STAGES-2:0], link.lockstep_i};
    lock_seen_next = lock_seen_reg;
    // Line level counts once the last two stages agree
    if (lock_sync_reg[1] == lock_sync_reg[2])
      lock_seen_next = ~lock_sync_reg[2];
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_sync_reg <= '1;
      lock_seen_reg <= 1'b0;
    end
    else
    begin
      lock_sync_reg <= lock_sync_next;
      lock_seen_reg <= lock_seen_next;
    end
  end
  // ==========================================
  // Backplane sequencing
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic [3:0] tick_reg;
  logic [3:0] tick_next;
  logic drive_reg;
  logic drive_next;
  logic fstart_reg;
  logic fstart_next;
  logic [1:0] last_phase;
  logic lock_fall;
  always_comb
  begin
    last_phase = link.mux_mode;
    lock_fall = lock_seen_next & ~lock_seen_reg & ~drive_reg;
    phase_next = phase_reg;
    tick_next = tick_reg;
    fstart_next = 1'b0;
    drive_next = drive_reg;
    if (lock_fall)
    begin
      // Another driver asserted first: join it at onset of last phase
      phase_next = last_phase;
      tick_next = LCDCS_TICK_RST;
    end
    else if (link.frame_tick)
    begin
      if (tick_reg == LCDCS_PHASE_TICKS - 4'h1)
      begin
        tick_next = LCDCS_TICK_RST;
        if (phase_reg >= last_phase)
        begin
          phase_next = LCDCS_PHASE_RST;
          fstart_next = 1'b1;
        end
        else
          phase_next = phase_reg + 2'h1;
      end
      else
        tick_next = tick_reg + 4'h1;
      // Pull low from onset of last phase until the next tick
      drive_next = (phase_next == last_phase) && (tick_next == LCDCS_TICK_RST);
    end
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // All drivers leave reset at phase zero together
      phase_reg <= LCDCS_PHASE_RST;
      tick_reg <= LCDCS_TICK_RST;
      drive_reg <= 1'b0;
      fstart_reg <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      tick_reg <= tick_next;
      drive_reg <= drive_next;
      fstart_reg <= fstart_next;
    end
  end
  // ==========================================
  // Data acceptance
  logic sel_hit_reg;
  logic sel_hit_next;
  logic acc_reg;
  logic acc_next;
  logic [7:0] dout_reg;
  logic [7:0] dout_next;
  always_comb
  begin
    // Match held until the next select
    sel_hit_next = sel_hit_reg;
    if (link.sel_valid)
      sel_hit_next = (link.sel_subaddr == subaddr_reg)
        && (link.sel_cluster == cluster_reg);
    acc_next = link.data_valid && sel_hit_reg;
    dout_next = dout_reg;
    if (link.data_valid && sel_hit_reg)
      dout_next = link.data_byte;
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_hit_reg <= 1'b0;
      acc_reg <= 1'b0;
      dout_reg <= 8'h00;
    end
    else
    begin
      sel_hit_reg <= sel_hit_next;
      acc_reg <= acc_next;
      dout_reg <= dout_next;
    end
  end
  // ==========================================
  // Outputs
  // Drive only low; pull-up supplies high
  assign link.lockstep_o = 1'b0;
  assign link.lockstep_oe = drive_reg;
  assign bp_phase = phase_reg;
  assign frame_start = fstart_reg;
  assign data_accept = acc_reg;
  assign data_out = dout_reg;
endmodule

// ---- verilog/lcdcs_ctrl.sv ----
// Controller end: frame clock source and subaddress select
module lcdcs_ctrl
  import lcdcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  lcdcs_if.ctrl link,
  input wire logic cmd_sel,
  input wire logic [3:0] cmd_device,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_data,
  input wire logic [1:0] cmd_mux,
  output logic lockstep_low
);
  // ==========================================
  // Frame clock source, single for the cascade
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic tick_reg;
  logic tick_next;
  logic selv_reg;
  logic selv_next;
  logic [3:0] dev_reg;
  logic [3:0] dev_next;
  logic dv_reg;
  logic dv_next;
  logic [7:0] db_reg;
  logic [7:0] db_next;
  logic [1:0] mux_reg;
  logic [1:0] mux_next;
  logic [2:0] lsync_reg;
  logic [2:0] lsync_next;
  logic low_reg;
  logic low_next;
  always_comb
  begin
    tick_next = 1'b0;
    div_next = div_reg + 16'h0001;
    if (div_reg == 16'(LCDCS_FRAME_DIV - 1))
    begin
      div_next = LCDCS_DIV_RST;
      tick_next = 1'b1;
    end
    selv_next = cmd_sel;
    dev_next = cmd_sel ? cmd_device : dev_reg;
    dv_next = cmd_write;
    db_next = cmd_write ? cmd_data : db_reg;
    // Mixed cluster mode change may desync; lockstep recovers it
    mux_next = cmd_mux;
    lsync_next = {lsync_reg[1:0], link.lockstep_i};
    low_next = low_reg;
    if (lsync_reg[1] == lsync_reg[2])
      low_next = ~lsync_reg[2];
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_reg <= LCDCS_DIV_RST;
      tick_reg <= 1'b0;
      selv_reg <= 1'b0;
      dev_reg <= 4'h0;
      dv_reg <= 1'b0;
      db_reg <= 8'h00;
      mux_reg <= LCDCS_MUX_4;
      lsync_reg <= 3'h7;
      low_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      selv_reg <= selv_next;
      dev_reg <= dev_next;
      dv_reg <= dv_next;
      db_reg <= db_next;
      mux_reg <= mux_next;
      lsync_reg <= lsync_next;
      low_reg <= low_next;
    end
  end
  // Same tick to every driver, equal delay
  assign link.frame_tick = tick_reg;
  assign link.sel_valid = selv_reg;
  assign link.sel_subaddr = dev_reg[2:0];
  assign link.sel_cluster = dev_reg[3];
  assign link.data_valid = dv_reg;
  assign link.data_byte = db_reg;
  assign link.mux_mode = mux_reg;
  assign lockstep_low = low_reg;
endmodule

// ---- bench/lcdcs_link_sva.sv ----
// Assertions on the controller to driver cascade link
module lcdcs_link_sva
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic frame_tick,
  input wire logic data_valid,
  input wire logic lockstep_o,
  input wire logic lockstep_oe,
  input wire logic lockstep_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] quiet_reg;
  logic [15:0] quiet_next;
  // ==========
  // Cycles since reset
  always_comb
  begin
    quiet_next = (quiet_reg == 16'hFFFF) ? quiet_reg : quiet_reg + 16'h0001;
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      quiet_reg <= 16'h0000;
    else
      quiet_reg <= quiet_next;
  end
  // ==========
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_drive_low_only: assert property (lockstep_oe |-> !lockstep_o)
    else $error("lockstep driven high");
  a_line_follows_oe: assert property (lockstep_oe |-> !lockstep_i)
    else $error("line not low while driven");
  a_oe_on_tick: assert property ($rose(lockstep_oe) |-> $past(frame_tick) || $past(frame_tick, 2))
    else $error("drive started off tick");
  a_oe_off_tick: assert property ($fell(lockstep_oe) |-> $past(frame_tick) || $past(frame_tick, 2))
    else $error("drive ended off tick");
  a_tick_pulse: assert property (frame_tick |=> !frame_tick)
    else $error("frame tick too long");
  a_data_pulse: assert property (data_valid |=> !data_valid)
    else $error("data strobe too long");
  a_quiet_tick: assert property (quiet_reg < 16'hBB80 |-> !frame_tick)
    else $error("early frame tick");
  a_quiet_drive: assert property (quiet_reg < 16'hBB80 |-> !lockstep_oe)
    else $error("early lockstep drive");
endmodule

// ---- bench/lcd_driver_cascade_sync_test.sv ----
// Self-checking bench for the cascade sync block
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module lcd_driver_cascade_sync_test
  import lcdcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] pins; logic [3:0] dev; logic [7:0] dat; logic acc;} lcdcs_row_s;
  lcdcs_row_s rows [4] = '{'{4'h5, 4'h5, 8'hA5, 1'b1}, '{4'h5, 4'hD, 8'h3C, 1'b0},
    '{4'h5, 4'h4, 8'hC3, 1'b0}, '{4'hC, 4'hC, 8'h96, 1'b1}};
  int miscompares = 0;
  int comparisons = 0;
  int oe_n;
  int fs_n;
  logic sys_clk = 0;
  logic rstn = 0;
  logic [3:0] pins = 4'h0;
  logic cmd_sel = 0;
  logic [3:0] cmd_device = 4'h0;
  logic cmd_write = 0;
  logic [7:0] cmd_data = 8'h00;
  logic lockstep_low, frame_start, data_accept, fs2, acc;
  logic [1:0] bp_phase, bp2;
  logic [7:0] data_out, got;
  lcdcs_if l ();
  lcdcs_if l2 ();
  assign l.lockstep_far = l2.lockstep_oe & ~l2.lockstep_o;
  assign l2.lockstep_far = l.lockstep_oe & ~l.lockstep_o;
  lcdcs_ctrl lcdcs_ctrl_i (.sys_clk(sys_clk), .rstn(rstn), .link(l), .cmd_sel(cmd_sel),
    .cmd_device(cmd_device), .cmd_write(cmd_write), .cmd_data(cmd_data), .cmd_mux(2'h1),
    .lockstep_low(lockstep_low));
  lcdcs_device lcdcs_device_i (.sys_clk(sys_clk), .rstn(rstn), .link(l),
    .hw_subaddr_bit_zero(pins[0]), .hw_subaddr_bit_one(pins[1]), .hw_subaddr_bit_two(pins[2]),
    .slave_address_cluster_select(pins[3]), .clock_source_select_pin(1'b1),
    .bp_phase(bp_phase), .frame_start(frame_start), .data_accept(data_accept),
    .data_out(data_out));
  lcdcs_device lcdcs_device_far_i (.sys_clk(sys_clk), .rstn(rstn), .link(l2),
    .hw_subaddr_bit_zero(pins[0]), .hw_subaddr_bit_one(pins[1]), .hw_subaddr_bit_two(pins[2]),
    .slave_address_cluster_select(pins[3]), .clock_source_select_pin(1'b1),
    .bp_phase(bp2), .frame_start(fs2), .data_accept(), .data_out());
  lcdcs_link_sva lcdcs_link_sva_i (.sys_clk(sys_clk), .rstn(rstn), .frame_tick(l.frame_tick),
    .data_valid(l.data_valid), .lockstep_o(l.lockstep_o), .lockstep_oe(l.lockstep_oe),
    .lockstep_i(l.lockstep_i));
  // ==========
  // Clock and tasks
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic sel(input logic [3:0] d);
    cmd_sel = 1;
    cmd_device = d;
    step(1);
  endtask
  task automatic wr(input logic [7:0] d);
    cmd_sel = 0;
    cmd_write = 1;
    cmd_data = d;
    step(1);
    cmd_write = 0;
    acc = 0;
    repeat (6)
    begin
      step(1);
      if (data_accept === 1'b1)
      begin
        acc = 1;
        got = data_out;
      end
    end
  endtask
  task automatic tick();
    l2.frame_tick = 1;
    for (int c = 0; c < 4; c++)
    begin
      step(1);
      if (c == 0)
        l2.frame_tick = 0;
      fs_n += (fs2 === 1'b1);
      oe_n += (l2.lockstep_oe === 1'b1);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial
  begin
    l2.frame_tick = 0;
    l2.sel_valid = 0;
    l2.sel_subaddr = 3'h0;
    l2.sel_cluster = 0;
    l2.data_valid = 0;
    l2.data_byte = 8'h00;
    l2.mux_mode = LCDCS_MUX_2;
    step(10);
    rstn = 1;
    foreach (rows[k])
    begin
      pins = rows[k].pins;
      step(5);
      sel(rows[k].dev);
      wr(rows[k].dat);
      `CHK("accept", rows[k].acc, acc)
      if (rows[k].acc) `CHK("data", rows[k].dat, got)
    end
    $display("rows done");
    for (int i = 0; i < 16; i++)
    begin
      pins = 4'(i);
      step(5);
      sel(4'(i));
      wr(8'(i));
      `CHK("index", 8'(i), got)
      sel(4'(i) ^ 4'h8);
      wr(8'h55);
      `CHK("cluster", 1'b0, acc)
    end
    sel(4'hF);
    sel(4'hE);
    wr(8'h11);
    `CHK("reselect off", 1'b0, acc)
    sel(4'hE);
    sel(4'hF);
    wr(8'h22);
    `CHK("reselect on", 8'h22, got)
    $display("addressing done");
    oe_n = 0;
    fs_n = 0;
    repeat (4) tick();
    `CHK("phase", 2'h1, bp2)
    `CHK("drive", 1'b1, l2.lockstep_oe)
    `CHK("line", 1'b0, l2.lockstep_i)
    step(2);
    `CHK("join phase", 2'h1, bp_phase)
    `CHK("join quiet", 1'b0, l.lockstep_oe)
    `CHK("line seen", 1'b1, lockstep_low)
    repeat (4) tick();
    `CHK("wrap", 2'h0, bp2)
    `CHK("frame", 1, fs_n)
    `CHK("drive seen", 1'b1, oe_n > 0)
    $display("frame done");
    step(50010);
    `CHK("line low", 1'b0, lockstep_low)
    rstn = 0;
    step(2);
    `CHK("rst accept", 1'b0, data_accept)
    `CHK("rst data", 8'h00, data_out)
    `CHK("rst phase", 2'h0, bp2)
    `CHK("rst join", 2'h0, bp_phase)
    rstn = 1;
    step(2);
    `CHK("rel phase", 2'h0, bp_phase)
    `CHK("rel line", 1'b0, lockstep_low)
    $display("reset done");
    tally_and_finish();
  end
endmodule
